// ===== hdl/cps_pkg.sv
// Package with modes, strap layout and register map of the pin select block
package cps_pkg;

	// ************************************************************
	// Interface modes, in selector order
	// ************************************************************
	typedef enum logic [1:0] {
		CPS_MUX_PAR,
		CPS_NONMUX_PAR,
		CPS_SERIAL,
		CPS_HARDWARE
	} cps_mode_type;

	// ************************************************************
	// Configuration set, from straps or from software
	// ************************************************************
	typedef struct packed {
		logic       jitter_clk_sel0;
		logic       rx_sync_func_sel;
		logic       tx_sync_func_sel;
		logic [2:0] tx_mode;
		logic [1:0] rx_mode;
		logic       tx_term_disable;
		logic       rx_term_disable;
	} cps_cfg_type;

	// Shared address/data pad drive; oe_n low where the block drives
	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe_n;
	} cps_pad_type;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int          CPS_ADDR_W       = 8;
	localparam logic [7:0]  CPS_CONFIG_OFS   = 8'h00;
	localparam logic [7:0]  CPS_STATUS_OFS   = 8'h04;
	localparam logic [7:0]  CPS_IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0]  CPS_IRQ_MASK_OFS = 8'h0C;

	localparam int          CPS_CFG_W        = 10;
	localparam logic [9:0]  CPS_CFG_RESET    = 10'h000;

	localparam int          CPS_IRQ_W        = 3;
	localparam int          CPS_IRQ_MODE_BIT = 0;
	localparam int          CPS_IRQ_RST_BIT  = 1;
	localparam int          CPS_IRQ_EVT_BIT  = 2;
	localparam logic [2:0]  CPS_IRQ_RESET    = 3'h0;
	localparam logic [2:0]  CPS_MASK_RESET   = 3'h0;

	localparam int          CPS_STAT_MODE_LSB = 0;
	localparam int          CPS_STAT_FLOAT    = 2;
	localparam int          CPS_STAT_SCLK     = 3;
	localparam int          CPS_STAT_CFG_LSB  = 4;

	// ************************************************************
	// Pad drive patterns
	// ************************************************************
	localparam logic [7:0]  CPS_OE_ALL       = 8'h00;
	localparam logic [7:0]  CPS_OE_SER       = 8'hFE;
	localparam logic [7:0]  CPS_OE_NONE      = 8'hFF;

	// Selector 2, float 1, pad 8, interrupt pin 1, transmit straps 3
	localparam int          CPS_SYNC_W       = 15;

endpackage

// ===== hdl/cps_sync2.sv
// Two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module cps_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// First stage feeds only the second stage
	logic [WIDTH-1:0] meta;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule

// ===== hdl/cps_pin_select.sv
// Controller port pin select: mode decode, strap capture, pad drive, APB
// Summary of operation
// - Selector 00 multiplexed, 01 nonmultiplexed parallel
// - Selector 10 serial port, 11 hardware straps
// - Nonmultiplexed mode: shared pins are data bus
// - Multiplexed mode: shared pins carry address then data
// - Hardware mode: bit 7 disables receive termination
// - Hardware mode: bit 6 disables transmit termination
// - Hardware mode: bits 5,4 select receive mode
// - Hardware mode: transmit straps select transmit mode
// - Hardware mode: bit 3 selects transmit sync function
// - Hardware mode: bit 2 selects receive sync function
// - Serial mode: bit 2 is host-driven serial clock
// - Open-drain interrupt pulled low on unmasked status events outside hardware mode
// - Float pin rising edge resets configuration registers
// - Float pin high floats the shared pads and the interrupt pin
// - Serial mode: bit 0 drives serial data out
`timescale 1ns/1ps
module cps_pin_select (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic [cps_pkg::CPS_ADDR_W-1:0] paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [1:0]                bus_iface_sel,
	input  wire logic                      float_or_reset_pin,
	input  wire logic [7:0]                ad_in,
	output cps_pkg::cps_pad_type           ad_pad,
	input  wire logic                      int_in,
	output logic                           int_out,
	output logic                           int_oe_n,
	input  wire logic                      tx_mode_sel0,
	input  wire logic                      tx_mode_sel1,
	input  wire logic                      tx_mode_sel2,
	input  wire logic                      par_ale,
	input  wire logic                      par_drive,
	input  wire logic [7:0]                par_rd_data,
	output logic      [7:0]                par_addr,
	output logic      [7:0]                par_data,
	input  wire logic                      serial_dout,
	input  wire logic                      serial_dout_en,
	output logic                           serial_clk,
	input  wire logic                      dev_event,
	output cps_pkg::cps_mode_type          mode,
	output cps_pkg::cps_cfg_type           cfg,
	output logic                           cfg_reset,
	output logic                           float_all,
	output logic                           irq
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [cps_pkg::CPS_SYNC_W-1:0] sync_in;
	logic [cps_pkg::CPS_SYNC_W-1:0] sync_out;
	logic [1:0]                     sel_s;
	logic                           float_s;
	logic [7:0]                     ad_s;
	logic                           int_s;
	logic [2:0]                     tx_sel_s;

	assign sync_in = {bus_iface_sel, float_or_reset_pin, ad_in, int_in,
		tx_mode_sel2, tx_mode_sel1, tx_mode_sel0};

	cps_sync2 #(
		.WIDTH    (cps_pkg::CPS_SYNC_W)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (sync_in),
		.sync_out (sync_out)
	);

	assign sel_s    = sync_out[14:13];
	assign float_s  = sync_out[12];
	assign ad_s     = sync_out[11:4];
	assign int_s    = sync_out[3];
	assign tx_sel_s = sync_out[2:0];

	// ************************************************************
	// Mode decode and float/reset pin
	// ************************************************************
	cps_pkg::cps_mode_type sel_mode;
	logic                  mode_loaded;
	logic [1:0]            settle;
	logic                  mode_evt;
	logic                  float_prev;
	logic                  float_rise;
	logic                  is_hw;
	logic                  is_ser;
	logic                  is_par;

	// Encoding of the enum follows the selector code directly
	assign sel_mode   = cps_pkg::cps_mode_type'(sel_s);
	assign is_hw      = (mode == cps_pkg::CPS_HARDWARE);
	assign is_ser     = (mode == cps_pkg::CPS_SERIAL);
	assign is_par     = (mode == cps_pkg::CPS_MUX_PAR) ||
		(mode == cps_pkg::CPS_NONMUX_PAR);
	// A live change is flagged; the board is expected to reset after it
	assign mode_evt   = mode_loaded && (sel_mode != mode);
	assign float_rise = float_s && !float_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode        <= cps_pkg::CPS_MUX_PAR;
			mode_loaded <= 1'b0;
			settle      <= 2'h0;
			float_prev  <= 1'b0;
			cfg_reset   <= 1'b0;
			float_all   <= 1'b0;
		end else begin
			mode        <= sel_mode;
			// The selector needs two edges to cross the synchroniser, so
			// the first real load after reset must not count as a change
			settle      <= {settle[0], 1'b1};
			mode_loaded <= settle[1];
			float_prev  <= float_s;
			cfg_reset   <= float_rise;
			float_all   <= float_s;
		end
	end

	// ************************************************************
	// Strap sourcing in hardware mode
	// ************************************************************
	cps_pkg::cps_cfg_type hw_cfg;
	cps_pkg::cps_cfg_type cfg_reg;

	// A strap pin at one asserts its function
	assign hw_cfg.rx_term_disable  = ad_s[7];
	assign hw_cfg.tx_term_disable  = ad_s[6];
	assign hw_cfg.rx_mode          = ad_s[5:4];
	assign hw_cfg.tx_mode          = tx_sel_s;
	assign hw_cfg.tx_sync_func_sel = ad_s[3];
	assign hw_cfg.rx_sync_func_sel = ad_s[2];
	// Board must strap this high for the listed master clocks
	assign hw_cfg.jitter_clk_sel0  = int_s;

	// Software configuration stands in for straps outside hardware mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= cps_pkg::cps_cfg_type'(cps_pkg::CPS_CFG_RESET);
		end else begin
			cfg <= is_hw ? hw_cfg : cfg_reg;
		end
	end

	// ************************************************************
	// Parallel and serial port data paths
	// ************************************************************
	logic drv_par;
	logic drv_ser;
	logic pads_live;
	logic [7:0] next_dout;

	// Float follows the registered level, so the pads stay off for exactly
	// as long as status reports the float; costs one cycle of latency
	assign pads_live = !float_all;

	// Straps never see a driver: only parallel modes or the serial out
	assign drv_par = is_par && par_drive && pads_live;
	assign drv_ser = is_ser && serial_dout_en && pads_live;

	assign ad_pad.oe_n = drv_par ? cps_pkg::CPS_OE_ALL :
		drv_ser ? cps_pkg::CPS_OE_SER : cps_pkg::CPS_OE_NONE;
	assign next_dout   = is_ser ? {7'h00, serial_dout} : par_rd_data;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ad_pad.dout <= 8'h00;
			par_data    <= 8'h00;
			par_addr    <= 8'h00;
			serial_clk  <= 1'b0;
		end else begin
			ad_pad.dout <= next_dout;
			par_data    <= is_par ? ad_s : 8'h00;
			if (mode == cps_pkg::CPS_MUX_PAR && par_ale) begin
				par_addr <= ad_s;
			end
			serial_clk  <= is_ser && ad_s[2];
		end
	end

	// ************************************************************
	// APB decode
	// ************************************************************
	logic        setup_ph;
	logic        access_ph;
	logic        wr_en;
	logic        hit_cfg;
	logic        hit_stat;
	logic        hit_ists;
	logic        hit_mask;
	logic        mapped;
	logic        err_q;
	logic [31:0] rd_mux;
	logic [31:0] stat_word;

	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable;
	assign wr_en     = access_ph && pwrite;
	assign hit_cfg   = (paddr == cps_pkg::CPS_CONFIG_OFS);
	assign hit_stat  = (paddr == cps_pkg::CPS_STATUS_OFS);
	assign hit_ists  = (paddr == cps_pkg::CPS_IRQ_STAT_OFS);
	assign hit_mask  = (paddr == cps_pkg::CPS_IRQ_MASK_OFS);
	assign mapped    = hit_cfg || hit_stat || hit_ists || hit_mask;

	// Zero wait states: read data is prepared during setup
	assign pready    = access_ph;
	assign pslverr   = access_ph && err_q;

	logic [cps_pkg::CPS_IRQ_W-1:0] irq_stat;
	logic [cps_pkg::CPS_IRQ_W-1:0] irq_mask;

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[cps_pkg::CPS_STAT_MODE_LSB +: 2] = mode;
		stat_word[cps_pkg::CPS_STAT_FLOAT] = float_all;
		stat_word[cps_pkg::CPS_STAT_SCLK] = serial_clk;
		stat_word[cps_pkg::CPS_STAT_CFG_LSB +: cps_pkg::CPS_CFG_W] = cfg;
	end

	// Narrow registers read back zero-extended to a full bus word
	logic [31:0] cfg_word;
	logic [31:0] ists_word;
	logic [31:0] mask_word;

	assign cfg_word  = {22'h0, cfg_reg};
	assign ists_word = {29'h0, irq_stat};
	assign mask_word = {29'h0, irq_mask};

	assign rd_mux = hit_cfg  ? cfg_word :
		hit_stat ? stat_word :
		hit_ists ? ists_word :
		hit_mask ? mask_word : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			err_q  <= 1'b0;
		end else if (setup_ph) begin
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			err_q  <= !mapped;
		end
	end

	// ************************************************************
	// Configuration and mask registers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg  <= cps_pkg::cps_cfg_type'(cps_pkg::CPS_CFG_RESET);
			irq_mask <= cps_pkg::CPS_MASK_RESET;
		end else if (float_rise) begin
			// Pin reset overrides a write landing in the same cycle
			cfg_reg  <= cps_pkg::cps_cfg_type'(cps_pkg::CPS_CFG_RESET);
			irq_mask <= cps_pkg::CPS_MASK_RESET;
		end else begin
			if (wr_en && hit_cfg) begin
				cfg_reg <= cps_pkg::cps_cfg_type'(
					pwdata[cps_pkg::CPS_CFG_W-1:0]);
			end
			if (wr_en && hit_mask) begin
				irq_mask <= pwdata[cps_pkg::CPS_IRQ_W-1:0];
			end
		end
	end

	// ************************************************************
	// Interrupt status and open-drain pin
	// ************************************************************
	logic [cps_pkg::CPS_IRQ_W-1:0] irq_set;
	logic [cps_pkg::CPS_IRQ_W-1:0] irq_clr;
	logic [cps_pkg::CPS_IRQ_W-1:0] next_irq_stat;

	always_comb begin
		irq_set = '0;
		irq_set[cps_pkg::CPS_IRQ_MODE_BIT] = mode_evt;
		irq_set[cps_pkg::CPS_IRQ_RST_BIT]  = float_rise;
		irq_set[cps_pkg::CPS_IRQ_EVT_BIT]  = dev_event;
	end

	assign irq_clr = (wr_en && hit_ists) ?
		pwdata[cps_pkg::CPS_IRQ_W-1:0] : '0;
	// A new event in the clearing cycle survives the clear
	assign next_irq_stat = (irq_stat & ~irq_clr) | irq_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= cps_pkg::CPS_IRQ_RESET;
		end else begin
			irq_stat <= next_irq_stat;
		end
	end

	assign irq      = |(irq_stat & irq_mask);
	// Pin doubles as a strap in hardware mode, so never drive it there
	assign int_out  = 1'b0;
	assign int_oe_n = !(irq && !is_hw && pads_live);

endmodule

// ===== bench/cps_pin_select_properties.sv
// Port-level checks of the controller port pin select block
`timescale 1ns/1ps
module cps_pin_select_properties (
	input logic                  pclk,
	input logic                  presetn,
	input logic [7:0]            ad_in,
	input cps_pkg::cps_pad_type  ad_pad,
	input logic                  int_oe_n,
	input logic                  tx_mode_sel0,
	input logic                  tx_mode_sel1,
	input logic                  tx_mode_sel2,
	input logic                  par_ale,
	input logic                  par_drive,
	input logic [7:0]            par_addr,
	input logic [7:0]            par_data,
	input logic                  serial_dout_en,
	input logic                  serial_clk,
	input cps_pkg::cps_mode_type mode,
	input cps_pkg::cps_cfg_type  cfg,
	input logic                  cfg_reset,
	input logic                  float_all,
	input logic                  irq
);
	logic [1:0] age;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Pin samples three edges back mean nothing until three edges after reset
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			age <= 2'h0;
		else if (age != 2'h3)
			age <= age + 2'h1;
	property p_no_drive;
		mode == cps_pkg::CPS_HARDWARE || float_all
			|-> ad_pad.oe_n == 8'hFF && int_oe_n;
	endproperty
	a_no_drive: assert property (p_no_drive) else $error("pad driven");
	property p_ser_pads;
		mode == cps_pkg::CPS_SERIAL && !float_all
			|-> ad_pad.oe_n == {7'h7F, !serial_dout_en};
	endproperty
	a_ser_pads: assert property (p_ser_pads) else $error("serial pads");
	property p_par_pads;
		!mode[1] && par_drive && !float_all |-> ad_pad.oe_n == 8'h00;
	endproperty
	a_par_pads: assert property (p_par_pads) else $error("parallel pads");
	property p_par_data;
		age == 2'h3 && !mode[1] && !$past(mode[1])
			|-> par_data == $past(ad_in, 3);
	endproperty
	a_par_data: assert property (p_par_data) else $error("data bus");
	property p_par_addr;
		age == 2'h3 && mode == cps_pkg::CPS_MUX_PAR && par_ale
			|=> par_addr == $past(ad_in, 3);
	endproperty
	a_par_addr: assert property (p_par_addr) else $error("address");
	property p_sclk;
		age == 2'h3 && mode == cps_pkg::CPS_SERIAL
			&& $past(mode) == cps_pkg::CPS_SERIAL
			|-> serial_clk == $past(ad_in[2], 3);
	endproperty
	a_sclk: assert property (p_sclk) else $error("serial clock");
	property p_terms;
		age == 2'h3 && mode == cps_pkg::CPS_HARDWARE
			&& $past(mode) == cps_pkg::CPS_HARDWARE
			|-> cfg.rx_term_disable == $past(ad_in[7], 3)
			&& cfg.tx_term_disable == $past(ad_in[6], 3);
	endproperty
	a_terms: assert property (p_terms) else $error("termination");
	property p_straps;
		age == 2'h3 && mode == cps_pkg::CPS_HARDWARE
			&& $past(mode) == cps_pkg::CPS_HARDWARE
			|-> {cfg.rx_mode, cfg.tx_sync_func_sel, cfg.rx_sync_func_sel}
			== $past(ad_in[5:2], 3);
	endproperty
	a_straps: assert property (p_straps) else $error("mode straps");
	property p_tx_mode;
		age == 2'h3 && mode == cps_pkg::CPS_HARDWARE
			&& $past(mode) == cps_pkg::CPS_HARDWARE
			|-> cfg.tx_mode == {$past(tx_mode_sel2, 3),
			$past(tx_mode_sel1, 3), $past(tx_mode_sel0, 3)};
	endproperty
	a_tx_mode: assert property (p_tx_mode) else $error("tx mode");
	property p_int;
		irq && mode != cps_pkg::CPS_HARDWARE && !float_all |-> !int_oe_n;
	endproperty
	a_int: assert property (p_int) else $error("interrupt pin");
	property p_cfg_rst;
		cfg_reset && mode != cps_pkg::CPS_HARDWARE
			|=> !cfg_reset ##[0:2] cfg == 10'h000;
	endproperty
	a_cfg_rst: assert property (p_cfg_rst) else $error("pin reset");
endmodule

bind cps_pin_select cps_pin_select_properties u_props (.pclk, .presetn,
	.ad_in, .ad_pad, .int_oe_n, .tx_mode_sel0, .tx_mode_sel1,
	.tx_mode_sel2, .par_ale, .par_drive, .par_addr, .par_data,
	.serial_dout_en, .serial_clk, .mode, .cfg, .cfg_reset, .float_all,
	.irq);

// ===== bench/cps_host_model.sv
// Host and board side of the shared pads and the interrupt pin
`timescale 1ns/1ps
module cps_host_model (
	input cps_pkg::cps_pad_type ad_pad,
	input logic [7:0]           host_oe_n,
	input logic [7:0]           host_dout,
	input logic                 int_oe_n,
	input logic                 int_strap,
	output logic [7:0]          ad_wire,
	output logic                int_wire
);
	// Lines nobody drives rise to the pull-up level
	always_comb
		for (int i = 0; i < 8; i++)
			ad_wire[i] = !ad_pad.oe_n[i] ? ad_pad.dout[i] :
				!host_oe_n[i] ? host_dout[i] : 1'b1;
	// Open drain: the strap resistor wins unless the device pulls low
	assign int_wire = !int_oe_n ? 1'b0 : int_strap;
endmodule

// ===== bench/cps_pin_select_test.sv
// Self-checking bench for the controller port pin select block
`timescale 1ns/1ps
module cps_pin_select_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic pready, pslverr, int_out, int_oe_n, int_w, err, sclk, irq;
	logic [7:0] paddr = 0, ad_w, par_addr, par_data, v;
	logic [7:0] prd = 0, h_oe_n = 8'hFF, h_do = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [1:0] bsel = 0;
	logic [2:0] txs = 0;
	logic flt = 0, strap = 0, ale = 0, pdrv = 0, sdo = 0, sdo_en = 0;
	logic evt = 0, cfg_rst, flt_all;
	cps_pkg::cps_pad_type ad_pad;
	cps_pkg::cps_mode_type mode;
	cps_pkg::cps_cfg_type cfg;
	int n_errors = 0, n_checks = 0, cyc = 0, seed = 47640, e_irq, e_cfg;
	int n_rst = 0;
	cps_pin_select dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .bus_iface_sel(bsel),
		.float_or_reset_pin(flt), .ad_in(ad_w), .ad_pad, .int_in(int_w),
		.int_out, .int_oe_n, .tx_mode_sel0(txs[0]), .tx_mode_sel1(txs[1]),
		.tx_mode_sel2(txs[2]), .par_ale(ale), .par_drive(pdrv),
		.par_rd_data(prd), .par_addr, .par_data, .serial_dout(sdo),
		.serial_dout_en(sdo_en), .serial_clk(sclk), .dev_event(evt), .mode,
		.cfg, .cfg_reset(cfg_rst), .float_all(flt_all), .irq);
	cps_host_model host (.ad_pad, .host_oe_n(h_oe_n), .host_dout(h_do),
		.int_oe_n, .int_strap(strap), .ad_wire(ad_w), .int_wire(int_w));
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cfg_rst === 1'b1)
			n_rst++;
		if (cyc == 5000) begin
			n_errors++;
			complete_run;
		end
	end
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic chk_reg(logic [7:0] a, logic [31:0] e, logic ee);
		apb(0, a, 0);
		chk("prdata", e, rd);
		chk("pslverr", 32'(ee), 32'(err));
	endtask
	initial begin
		tick(2);
		presetn <= 1;
		tick(4);
		for (int a = 0; a < 16; a += 4)
			chk_reg(8'(a), 0, 0);
		chk_reg(8'h10, 0, 1);
		e_cfg = $random(seed) & 32'h3FF | 32'h1;
		apb(1, 8'h00, e_cfg);
		chk_reg(8'h00, e_cfg, 0);
		chk("cfg", e_cfg, 32'(cfg));
		for (int m = 0; m < 4; m++) begin
			v = 8'($random(seed));
			{strap, txs} <= 4'($random(seed));
			bsel <= 2'(m);
			h_do <= v;
			h_oe_n <= (m == 2) ? 8'h01 : 8'h00;
			pdrv <= (m == 3);
			tick(5);
			chk("mode", m, 32'(mode));
			if (m < 2) begin
				chk("par_data", v, par_data);
				ale <= 1;
				tick(1);
				ale <= 0;
				tick(1);
				if (m == 0)
					chk("par_addr", v, par_addr);
				h_oe_n <= 8'hFF;
				pdrv <= 1;
				prd <= ~v;
				tick(2);
				chk("oe_n", 0, ad_pad.oe_n);
				chk("dout", {24'h0, ~v}, ad_pad.dout);
			end else if (m == 2) begin
				chk("serial_clk", v[2], sclk);
				sdo_en <= 1;
				sdo <= ~v[0];
				tick(2);
				chk("oe_n", 8'hFE, ad_pad.oe_n);
				chk("dout0", {31'h0, ~v[0]}, ad_pad.dout[0]);
				sdo_en <= 0;
			end else begin
				chk("cfg", {strap, v[2], v[3], txs, v[5:4], v[6], v[7]},
					32'(cfg));
				chk("oe_n", 8'hFF, ad_pad.oe_n);
			end
		end
		bsel <= 0;
		h_oe_n <= 8'hFF;
		pdrv <= 0;
		tick(5);
		e_irq = 1;
		chk_reg(8'h08, e_irq, 0);
		apb(1, 8'h0C, 32'h4);
		evt <= 1;
		tick(1);
		evt <= 0;
		tick(2);
		chk("irq", 1, irq);
		chk("int_oe_n", 0, int_oe_n);
		e_irq |= 4;
		chk_reg(8'h08, e_irq, 0);
		apb(1, 8'h0C, 32'h0);
		tick(1);
		chk("irq", 0, irq);
		apb(1, 8'h08, e_irq);
		chk_reg(8'h08, 0, 0);
		apb(1, 8'h00, e_cfg);
		apb(1, 8'h0C, 32'h2);
		pdrv <= 1;
		flt <= 1;
		tick(6);
		chk("float_all", 1, flt_all);
		chk("oe_n", 8'hFF, ad_pad.oe_n);
		chk("int_oe_n", 1, int_oe_n);
		chk("cfg_reset", 1, n_rst);
		chk("int_out", 0, int_out);
		chk_reg(8'h00, 0, 0);
		chk_reg(8'h08, 2, 0);
		chk_reg(8'h0C, 0, 0);
		flt <= 0;
		tick(3);
		bsel <= 3;
		presetn <= 0;
		tick(2);
		presetn <= 1;
		tick(6);
		chk("mode", 3, 32'(mode));
		chk_reg(8'h08, 0, 0);
		complete_run;
	end
endmodule
